// ### dcr_regs.sv
/*
  Deflection control register bank with its serial control slave.
  Assumes a two-wire control link (clock pin and open-drain data pin)
  oversampled by linkClk, and same-clock blanking inputs.
*/
`timescale 1ns/100ps
`default_nettype none
module dcr_regs #(
  parameter int LINE_PERIOD_CYC = dcr_pkg::LINE_PERIOD_DEF
) (
  // System clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // Link oversampling clock and pins
  input  wire logic              linkClk,
  input  wire logic              sclIn,
  input  wire logic              sdaIn,
  output var  logic              sdaOut,
  output var  logic              sdaOe,
  // Straps and pins
  input  wire logic              externalClockSelectPin,
  input  wire logic              softStartPin,
  input  wire logic              lineRangePin,
  input  wire logic              hsyncIn,
  // Same-clock blanking inputs
  input  wire logic              lineBlankIn,
  input  wire logic              verticalBlankIn,
  // Control outputs
  output var  dcr_pkg::dcr_ctl_t ctl,
  output var  logic              lineDriveOutput,
  output var  logic              pwmOutput,
  output var  logic              sandcastleOutput,
  output var  logic              syncAccepted
);
  import dcr_pkg::*;

  // Line drive low time per duty choice
  localparam logic [15:0] LINE_LAST = 16'(LINE_PERIOD_CYC - 1);
  localparam logic [15:0] LOW_WIDE  =
    16'(LINE_PERIOD_CYC * DUTY_WIDE_PCT / 100);
  localparam logic [15:0] LOW_NARROW =
    16'(LINE_PERIOD_CYC * DUTY_NARROW_PCT / 100);

  dcr_sys_t  s, next_s;        // System-domain state
  dcr_link_t l, next_l;        // Link-domain state
  logic [1:0] rstPipe;         // System reset release
  logic [1:0] lrstPipe;        // Link reset release
  logic       sysRst_n;        // Synchronised system reset
  logic       linkRst_n;       // Synchronised link reset

  assign sysRst_n  = rstPipe[1];
  assign linkRst_n = lrstPipe[1];

  // Register read decode, only implemented bits show
  function automatic logic [7:0] readReg(input dcr_sys_t st,
                                         input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      SUB_MAIN:  v = st.main;
      SUB_AUX:   v = st.aux;
      SUB_VSYNC: v = st.vsync & MASK_VSYNC;
      SUB_PWM:   v = st.pwm;
      SUB_PLL0:  v = st.pll0 & MASK_PLL0;
      SUB_PLL1:  v = st.pll1 & MASK_PLL1;
      default:   v = 8'h00;
    endcase
    return v;
  endfunction

  // Reset release, system domain
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end

  // Reset release, link domain
  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      lrstPipe <= 2'h0;
    end else begin
      lrstPipe <= {lrstPipe[0], 1'b1};
    end
  end

  // System domain: registers, crossing answer, generators
  always_comb begin
    logic       black_switchoff_mode;
    logic       lock;
    logic [6:0] duty;
    logic [15:0] lowCnt;
    black_switchoff_mode    = 1'b0;
    lock   = 1'b0;
    duty   = 7'h00;
    lowCnt = 16'h0000;
    next_s = s;
    // Synchronisers: first stage feeds only the second
    next_s.reqS1 = l.reqTog;
    next_s.reqS2 = s.reqS1;
    next_s.reqS3 = s.reqS2;
    next_s.ssS1  = softStartPin;
    next_s.ssS2  = s.ssS1;
    next_s.lrS1  = lineRangePin;
    next_s.lrS2  = s.lrS1;
    next_s.exS1  = externalClockSelectPin;
    next_s.exS2  = s.exS1;
    next_s.hsS1  = hsyncIn;
    next_s.hsS2  = s.hsS1;
    next_s.hsS3  = s.hsS2;
    // Straps caught once the pin synchronisers have filled
    if (!s.strapDone) begin
      if (s.strapCnt == STRAP_WAIT) begin
        next_s.strapDone  = 1'b1;
        next_s.softStart  = s.ssS2;
        next_s.lineRange  = s.lrS2;
        next_s.main[B_HDEN] = s.ssS2;
      end else begin
        next_s.strapCnt = s.strapCnt + 2'h1;
      end
    end
    // New link request: write, then answer with read data
    if (s.reqS2 != s.reqS3) begin
      if (l.req.wr) begin
        unique case (l.req.addr)
          SUB_MAIN:  next_s.main  = l.req.data;
          SUB_AUX:   next_s.aux   = l.req.data;
          SUB_VSYNC: next_s.vsync = l.req.data & MASK_VSYNC;
          SUB_PWM:   next_s.pwm   = l.req.data;
          SUB_PLL0: begin
            next_s.pll0 = l.req.data & MASK_PLL0;
            next_s.incrWritten = 1'b1;
          end
          SUB_PLL1:  next_s.pll1  = l.req.data & MASK_PLL1;
          default: begin
            // Unmapped or out-of-bank subaddress: ignored
          end
        endcase
      end
      next_s.rdData = readReg(next_s, l.req.addr);
      next_s.ack    = ~s.ack;
    end

    // Decoded controls
    black_switchoff_mode  = s.aux[B_BSOH] | s.aux[B_BSOL];
    lock = s.softStart & ~s.lineRange;
    next_s.ctl.vertOutputKill     = s.main[B_VKILL];
    next_s.ctl.vertProtectEnable  = ~s.main[B_VKILL];
    next_s.ctl.standbyRequest     = s.main[B_STANDBY_REQUEST];
    next_s.ctl.autoLineRateDetect = s.main[B_MON];
    // Bus choice only counts when bus selection is on
    next_s.ctl.externalClockChosen = s.main[B_CSBUS] ?
      s.main[B_CLKX] : s.exS2;
    next_s.ctl.beamCurrentRange    = s.main[B_BEAMR];
    next_s.ctl.lineDriveDutySelect = s.main[B_DUTY];
    next_s.ctl.lineDriveRunning    = s.main[B_HDEN] | black_switchoff_mode;
    next_s.ctl.blackSwitchoffMode  = s.aux[B_BSOH:B_BSOL];
    next_s.ctl.selfAdaptOn         = ~s.aux[B_NSA];
    next_s.ctl.driveClipOn         = ~s.aux[B_DRIVE_CLIP_DISABLE];
    next_s.ctl.guardBandItemsOn    = s.aux[B_GBE];
    next_s.ctl.vertDynamicComp     = s.aux[B_VDC];
    next_s.ctl.shrinkOverscanJump  = s.aux[B_JMP];
    next_s.ctl.blankingItemsOn     = s.aux[B_BSE];
    next_s.ctl.forceProgressive    = s.vsync[B_NI];
    next_s.ctl.pwmModeSelect       = s.pwm[B_PWS1:B_PWS0];
    next_s.ctl.pwmLevelCode        = s.pwm[B_PWCH:B_PWCL];
    // Strap lock pins the increment; bus value used once written
    next_s.ctl.pllFreqIncrement = lock ? PLL_FREQ_INCREMENT_DEF_SS :
      (s.incrWritten ? s.pll0[4:0] : PLL_FREQ_INCREMENT_DEF);
    next_s.ctl.freeRunGenerator   = s.pll1[B_GEN];
    next_s.ctl.tapeFilterMode     = s.pll1[B_TAPE];
    next_s.ctl.noisyTapeHandling  =
      s.pll1[B_NOIS] & s.pll1[B_TAPE];
    next_s.ctl.thirdLoopTimeConstant =
      s.pll1[B_TC3] & s.pll1[B_TAPE];
    next_s.ctl.minSyncWidthSelect = s.pll1[B_SWID];

    // Generators freeze while in standby
    if (!s.main[B_STANDBY_REQUEST]) begin
      // Line drive: low part of each line, high when switched off
      lowCnt = s.main[B_DUTY] ? LOW_NARROW : LOW_WIDE;
      next_s.lineCnt = (s.lineCnt == LINE_LAST) ? 16'h0000 :
        s.lineCnt + 16'h0001;
      if (s.main[B_HDEN] | black_switchoff_mode) begin
        next_s.lineDrv = (s.lineCnt >= lowCnt);
      end else begin
        next_s.lineDrv = 1'b1;
      end
      // Fixed-duty PWM; parabola modes are shaped downstream
      next_s.pwmCnt = (s.pwmCnt == PWM_LAST) ? 7'h00 :
        s.pwmCnt + 7'h01;
      duty = {~s.pwm[B_PWCH], s.pwm[B_PWCH-1:B_PWCL],
              s.pwm[B_PWS1]};
      if (!s.pwm[B_PWS0]) begin
        next_s.pwmOut = (s.pwmCnt < duty);
      end else begin
        next_s.pwmOut = 1'b0;
      end
      // Sync width qualifier
      if (s.hsS2) begin
        if (s.hsCnt != 9'h1ff) begin
          next_s.hsCnt = s.hsCnt + 9'h001;
        end
      end else begin
        next_s.hsCnt = 9'h000;
      end
      next_s.syncOk = s.hsS3 & ~s.hsS2 & (s.hsCnt >=
        (s.pll1[B_SWID] ? SYNC_FAST_CYC : SYNC_SLOW_CYC));
    end else begin
      next_s.syncOk = 1'b0;
    end
    // Sandcastle: line blank plus optional vertical blank
    next_s.sandcastle = lineBlankIn |
      (verticalBlankIn & ~s.vsync[B_SSC]);
  end

  // System domain state register
  always_ff @(posedge sys_clk or negedge sysRst_n) begin
    if (!sysRst_n) begin
      s          <= '0;
      s.main     <= REG_RST;
      s.lineDrv  <= 1'b1;
      s.ctl.vertProtectEnable <= 1'b1;
      s.ctl.selfAdaptOn       <= 1'b1;
      s.ctl.driveClipOn       <= 1'b1;
      s.ctl.pllFreqIncrement  <= PLL_FREQ_INCREMENT_DEF;
    end else begin
      s <= next_s;
    end
  end

  // Link domain: two-wire slave with auto-incrementing pointer
  always_comb begin
    logic sclRise, sclFall, startC, stopC;
    sclRise = l.scS2 & ~l.sandcastle_output;
    sclFall = ~l.scS2 & l.sandcastle_output;
    startC  = l.scS2 & l.sandcastle_output & l.sdP & ~l.sdS2;
    stopC   = l.scS2 & l.sandcastle_output & ~l.sdP & l.sdS2;
    next_l = l;
    next_l.scS1 = sclIn;
    next_l.scS2 = l.scS1;
    next_l.sandcastle_output  = l.scS2;
    next_l.sdS1 = sdaIn;
    next_l.sdS2 = l.sdS1;
    next_l.sdP  = l.sdS2;
    next_l.akS1 = s.ack;
    next_l.akS2 = l.akS1;
    next_l.akS3 = l.akS2;
    // Answer from the system side holds read data
    if (l.akS2 != l.akS3) begin
      next_l.rdBuf = s.rdData;
    end
    if (startC) begin
      next_l.st     = LS_RX;
      next_l.kind   = BK_ADDR;
      next_l.bitCnt = 4'h0;
      next_l.sdaOe  = 1'b0;
    end else if (stopC) begin
      next_l.st    = LS_IDLE;
      next_l.sdaOe = 1'b0;
    end else begin
      unique case (l.st)
        LS_IDLE: begin
          next_l.sdaOe = 1'b0;
        end
        LS_RX: begin
          if (sclRise) begin
            next_l.shift  = {l.shift[6:0], l.sdS2};
            next_l.bitCnt = l.bitCnt + 4'h1;
          end else if (sclFall && l.bitCnt == BYTE_BITS) begin
            next_l.st    = LS_ACK;
            next_l.sdaOe = 1'b1;
            unique case (l.kind)
              BK_ADDR: begin
                next_l.rd = l.shift[0];
                if (l.shift[7:1] != DEV_ADDR) begin
                  next_l.st    = LS_IDLE;
                  next_l.sdaOe = 1'b0;
                end else if (l.shift[0]) begin
                  // Reads restart at the last subaddress written
                  next_l.ptr    = l.lastSub;
                  next_l.req    = '{1'b0, l.lastSub, 8'h00};
                  next_l.reqTog = ~l.reqTog;
                end
              end
              BK_SUB: begin
                next_l.ptr     = l.shift;
                next_l.lastSub = l.shift;
              end
              default: begin
                next_l.req    = '{1'b1, l.ptr, l.shift};
                next_l.reqTog = ~l.reqTog;
                next_l.ptr    = l.ptr + 8'h01;
              end
            endcase
          end
        end
        LS_ACK: begin
          if (sclFall) begin
            next_l.bitCnt = 4'h0;
            if (l.rd) begin
              next_l.st    = LS_TX;
              next_l.shift = l.rdBuf;
              next_l.sdaOe = ~l.rdBuf[7];
            end else begin
              next_l.st    = LS_RX;
              next_l.kind  = (l.kind == BK_ADDR) ? BK_SUB : BK_DATA;
              next_l.sdaOe = 1'b0;
            end
          end
        end
        LS_TX: begin
          if (sclFall) begin
            next_l.bitCnt = l.bitCnt + 4'h1;
            next_l.shift  = {l.shift[6:0], 1'b0};
            if (l.bitCnt == LAST_BIT) begin
              next_l.st    = LS_TXACK;
              next_l.sdaOe = 1'b0;
            end else begin
              next_l.sdaOe = ~l.shift[6];
            end
          end
        end
        LS_TXACK: begin
          if (sclRise) begin
            next_l.mAck = ~l.sdS2;
            if (!l.sdS2) begin
              // Prefetch the next byte before the falling edge
              next_l.ptr    = l.ptr + 8'h01;
              next_l.req    = '{1'b0, l.ptr + 8'h01, 8'h00};
              next_l.reqTog = ~l.reqTog;
            end
          end else if (sclFall) begin
            if (l.mAck) begin
              next_l.st     = LS_TX;
              next_l.bitCnt = 4'h0;
              next_l.shift  = l.rdBuf;
              next_l.sdaOe  = ~l.rdBuf[7];
            end else begin
              next_l.st = LS_IDLE;
            end
          end
        end
        default: begin
          next_l.st    = LS_IDLE;
          next_l.sdaOe = 1'b0;
        end
      endcase
    end
  end

  // Link domain state register
  always_ff @(posedge linkClk or negedge linkRst_n) begin
    if (!linkRst_n) begin
      l      <= '0;
      l.st   <= LS_IDLE;
      l.kind <= BK_ADDR;
      l.scS1 <= 1'b1;
      l.scS2 <= 1'b1;
      l.sandcastle_output  <= 1'b1;
      l.sdS1 <= 1'b1;
      l.sdS2 <= 1'b1;
      l.sdP  <= 1'b1;
    end else begin
      l <= next_l;
    end
  end

  // Outputs straight from state flops; data pin only pulls low
  assign sdaOut           = 1'b0;
  assign sdaOe            = l.sdaOe;
  assign ctl              = s.ctl;
  assign lineDriveOutput  = s.lineDrv;
  assign pwmOutput        = s.pwmOut;
  assign sandcastleOutput = s.sandcastle;
  assign syncAccepted     = s.syncOk;
endmodule
`default_nettype wire

// ### dcr_pkg.sv
/*
  Constants, field layouts and carrier types of the deflection control
  register bank.
  Assumes a system clock of 200 MHz and a serial control link whose
  oversampling clock is unrelated to it.
*/
package dcr_pkg;

  // Subaddresses
  localparam logic [7:0] SUB_MAIN  = 8'h00;
  localparam logic [7:0] SUB_AUX   = 8'h01;
  localparam logic [7:0] SUB_VSYNC = 8'h18;
  localparam logic [7:0] SUB_PWM   = 8'h1b;
  localparam logic [7:0] SUB_PLL0  = 8'h1c;
  localparam logic [7:0] SUB_PLL1  = 8'h1d;
  // Implemented bits per register, and the main register reset value
  localparam logic [7:0] MASK_VSYNC = 8'h28;
  localparam logic [7:0] MASK_PLL0  = 8'h1f;
  localparam logic [7:0] MASK_PLL1  = 8'h1f;
  localparam logic [7:0] REG_RST    = 8'h00;
  // Main control fields
  localparam int B_VKILL = 7;
  localparam int B_STANDBY_REQUEST = 6;
  localparam int B_MON   = 5;
  localparam int B_CSBUS = 4;
  localparam int B_BEAMR = 3;
  localparam int B_CLKX  = 2;
  localparam int B_DUTY  = 1;
  localparam int B_HDEN  = 0;
  // Aux control fields
  localparam int B_BSOH = 7;
  localparam int B_BSOL = 6;
  localparam int B_NSA  = 5;
  localparam int B_DRIVE_CLIP_DISABLE = 4;
  localparam int B_GBE  = 3;
  localparam int B_VDC  = 2;
  localparam int B_JMP  = 1;
  localparam int B_BSE  = 0;
  // Vertical sync and PWM fields
  localparam int B_SSC  = 5;
  localparam int B_NI   = 3;
  localparam int B_PWCH = 7;
  localparam int B_PWCL = 2;
  localparam int B_PWS1 = 1;
  localparam int B_PWS0 = 0;
  // Loop option fields
  localparam int B_GEN  = 4;
  localparam int B_TAPE = 3;
  localparam int B_NOIS = 2;
  localparam int B_SWID = 1;
  localparam int B_TC3  = 0;
  // Increment defaults
  localparam logic [4:0] PLL_FREQ_INCREMENT_DEF    = 5'h06;
  localparam logic [4:0] PLL_FREQ_INCREMENT_DEF_SS = 5'h14;
  // Timing
  localparam int SYS_CLK_MHZ      = 200;
  localparam int SYS_CLK_HZ       = 200_000_000;
  localparam int SYNC_MIN_SLOW_NS = 1500;
  localparam int SYNC_MIN_FAST_NS = 800;
  localparam logic [8:0] SYNC_SLOW_CYC =
    9'((SYNC_MIN_SLOW_NS * SYS_CLK_MHZ + 999) / 1000);
  localparam logic [8:0] SYNC_FAST_CYC =
    9'((SYNC_MIN_FAST_NS * SYS_CLK_MHZ + 999) / 1000);
  localparam int LINE_FREQ_HZ    = 31_250;
  localparam int LINE_PERIOD_DEF = SYS_CLK_HZ / LINE_FREQ_HZ;
  localparam int DUTY_WIDE_PCT   = 45;
  localparam int DUTY_NARROW_PCT = 40;
  localparam logic [6:0] PWM_LAST = 7'h6b;
  localparam logic [1:0] STRAP_WAIT = 2'h2;
  // Serial link
  localparam logic [6:0] DEV_ADDR = 7'h2a;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT  = 4'h7;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } dcr_req_t;

  typedef struct packed {
    logic       vertOutputKill;
    logic       vertProtectEnable;
    logic       standbyRequest;
    logic       autoLineRateDetect;
    logic       externalClockChosen;
    logic       beamCurrentRange;
    logic       lineDriveDutySelect;
    logic       lineDriveRunning;
    logic [1:0] blackSwitchoffMode;
    logic       selfAdaptOn;
    logic       driveClipOn;
    logic       guardBandItemsOn;
    logic       vertDynamicComp;
    logic       shrinkOverscanJump;
    logic       blankingItemsOn;
    logic       forceProgressive;
    logic [1:0] pwmModeSelect;
    logic [5:0] pwmLevelCode;
    logic [4:0] pllFreqIncrement;
    logic       freeRunGenerator;
    logic       tapeFilterMode;
    logic       noisyTapeHandling;
    logic       thirdLoopTimeConstant;
    logic       minSyncWidthSelect;
  } dcr_ctl_t;

  typedef enum logic [2:0] {
    LS_IDLE, LS_RX, LS_ACK, LS_TX, LS_TXACK
  } dcr_lst_t;

  typedef enum logic [1:0] {BK_ADDR, BK_SUB, BK_DATA} dcr_kind_t;

  typedef struct packed {
    logic       reqS1, reqS2, reqS3, ack;
    logic [7:0] rdData;
    logic [7:0] main, aux, vsync, pwm, pll0, pll1;
    logic       incrWritten, strapDone, softStart, lineRange;
    logic [1:0] strapCnt;
    logic       ssS1, ssS2, lrS1, lrS2, exS1, exS2;
    logic       hsS1, hsS2, hsS3, syncOk;
    logic [8:0] hsCnt;
    logic [15:0] lineCnt;
    logic       lineDrv;
    logic [6:0] pwmCnt;
    logic       pwmOut, sandcastle;
    dcr_ctl_t   ctl;
  } dcr_sys_t;

  typedef struct packed {
    logic       scS1, scS2, sandcastle_output, sdS1, sdS2, sdP;
    dcr_lst_t   st;
    dcr_kind_t  kind;
    logic [3:0] bitCnt;
    logic [7:0] shift, ptr, lastSub;
    logic       rd, mAck;
    dcr_req_t   req;
    logic       reqTog, akS1, akS2, akS3;
    logic [7:0] rdBuf;
    logic       sdaOe;
  } dcr_link_t;
endpackage

// ### dcr_regs_assertions.sv
/*
  Checker for the deflection control register bank outputs.
  Sees only the top module's ports; the bench binds it.
*/
`timescale 1ns/100ps
`default_nettype none
module dcr_regs_assertions (
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              rst_n,
  // Watched ports
  input wire logic              sdaOe,
  input wire logic              lineBlankIn,
  input wire logic              verticalBlankIn,
  input wire dcr_pkg::dcr_ctl_t ctl,
  input wire logic              lineDriveOutput,
  input wire logic              pwmOutput,
  input wire logic              sandcastleOutput
);
  import dcr_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Fixed-duty code at full scale, held long enough to reach the pin
  sequence sFullCode;
    (!ctl.standbyRequest && !ctl.pwmModeSelect[0]
      && ctl.pwmLevelCode == 6'h1f) [*3];
  endsequence
  // Fixed-duty code at the bottom with the low count bit clear
  sequence sZeroCode;
    (!ctl.standbyRequest && ctl.pwmModeSelect == 2'h0
      && ctl.pwmLevelCode == 6'h20) [*3];
  endsequence
  AST_KILL_PROT: assert property (ctl.vertOutputKill |->
    !ctl.vertProtectEnable) else $error("protection on while killed");
  AST_DRV_OFF: assert property ((!ctl.lineDriveRunning) [*3] |->
    lineDriveOutput) else $error("line drive not held high");
  AST_BSO_RUN: assert property (ctl.blackSwitchoffMode != 2'h0 |->
    ctl.lineDriveRunning) else $error("line stopped under switch-off");
  AST_TAPE_SUB: assert property (!ctl.tapeFilterMode |->
    !ctl.noisyTapeHandling && !ctl.thirdLoopTimeConstant)
    else $error("tape sub-bits active outside tape mode");
  AST_PWM_FULL: assert property (sFullCode |-> pwmOutput)
    else $error("full code output not high");
  AST_PWM_ZERO: assert property (sZeroCode |-> !pwmOutput)
    else $error("bottom code output not low");
  AST_PARAB_LOW: assert property ((ctl.pwmModeSelect[0] &&
    !ctl.standbyRequest) [*3] |-> !pwmOutput)
    else $error("duty pulses in parabola mode");
  AST_SAND_LINE: assert property (lineBlankIn |=>
    sandcastleOutput) else $error("line blank missing on sandcastle");
  AST_SAND_IDLE: assert property (!lineBlankIn && !verticalBlankIn |=>
    !sandcastleOutput) else $error("sandcastle high without blanking");
  AST_ACK_HOLD: assert property ($rose(sdaOe) |=> sdaOe [*8])
    else $error("data line pull shorter than a bit slot");
endmodule
`default_nettype wire

// ### dcr_link_master.sv
/*
  Behavioural two-wire bus host standing in for the controller.
  Assumes the bench resolves the data line with a pull-up.
*/
`timescale 1ns/100ps
`default_nettype none
module dcr_link_master #(
  parameter int HALF_NS = 170
) (
  // Bus pins
  output var  logic sclOut,
  output var  logic sdaRelease,
  input  wire logic sdaWire
);
  // Both lines idle released; clock stands still between frames
  initial begin
    sclOut = 1'b1;
    sdaRelease = 1'b1;
  end
  // Data falls while the clock is high
  task automatic busStart();
    sdaRelease = 1'b0;
    #HALF_NS;
    sclOut = 1'b0;
  endtask
  // Data rises while the clock is high
  task automatic busStop();
    #(HALF_NS / 4);
    sdaRelease = 1'b0;
    #HALF_NS;
    sclOut = 1'b1;
    #HALF_NS;
    sdaRelease = 1'b1;
    #HALF_NS;
  endtask
  // Nine slots MSB first; data moves well clear of the clock fall
  task automatic xfer(input logic [8:0] o, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      #(HALF_NS / 4);
      sdaRelease = o[i];
      #HALF_NS;
      sclOut = 1'b1;
      #HALF_NS;
      r[i] = sdaWire;
      sclOut = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ### tb_top.sv
/*
  Self-checking bench for the deflection control register bank.
  Assumes the package, design, host model and checker compile first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import dcr_pkg::*;
  localparam int LP = 40;            // Short line period
  logic sys_clk = 1'b0;              // 200 MHz
  logic linkClk = 1'b0;              // 6 ns, own phase
  logic rst_n = 1'b0;
  logic hsyncIn = 1'b0;
  logic lineBlankIn = 1'b0;
  logic verticalBlankIn = 1'b0;
  logic scl, sdaRel, sdaOe, lineDrv, pwmOut, sandOut, syncOk;
  logic [7:0] rdA, rdB;              // Last bytes read back
  dcr_ctl_t ctl;
  wire logic sda = sdaRel & ~sdaOe;  // Pulled-up data line
  int miscompares = 0;
  int num_checks = 0;
  initial forever #2.5 sys_clk = ~sys_clk;
  initial begin
    #1.3;
    forever #3 linkClk = ~linkClk;
  end
  dcr_regs #(.LINE_PERIOD_CYC(LP)) dut_u (.sys_clk, .rst_n, .linkClk,
    .sclIn(scl), .sdaIn(sda), .sdaOut(), .sdaOe,
    .externalClockSelectPin(1'b0), .softStartPin(1'b1),
    .lineRangePin(1'b0), .hsyncIn, .lineBlankIn, .verticalBlankIn, .ctl,
    .lineDriveOutput(lineDrv), .pwmOutput(pwmOut),
    .sandcastleOutput(sandOut), .syncAccepted(syncOk));
  dcr_link_master hm (.sclOut(scl), .sdaRelease(sdaRel), .sdaWire(sda));
  // Compare and count
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Pointer and optional data byte, then let the update land
  task automatic regWrite(input logic [7:0] sub, input logic [7:0] d,
                          input logic withData);
    logic [8:0] r0, r1, r2;
    r2 = '0;
    hm.busStart();
    hm.xfer({DEV_ADDR, 2'b01}, r0);
    hm.xfer({sub, 1'b1}, r1);
    if (withData) hm.xfer({d, 1'b1}, r2);
    hm.busStop();
    check({r0[0], r1[0], r2[0]}, 3'h0);
    repeat (10) @(posedge sys_clk);
  endtask
  // Two bytes from the last written pointer onward
  task automatic readPair();
    logic [8:0] r0, r1, r2;
    hm.busStart();
    hm.xfer({DEV_ADDR, 2'b11}, r0);
    hm.xfer(9'h1fe, r1);
    hm.xfer(9'h1ff, r2);
    hm.busStop();
    {rdA, rdB} = {r1[8:1], r2[8:1]};
    check(r0[0], 1'b0);
    @(posedge sys_clk);
  endtask
  // Low cycles of the line drive over one line
  task automatic lowCount(output int lows);
    lows = 0;
    repeat (2 * LP) @(posedge sys_clk);
    repeat (LP) begin
      @(posedge sys_clk);
      lows += int'(lineDrv === 1'b0);
    end
  endtask
  // A 1 us sync pulse passes only the short minimum width
  task automatic syncTry(input logic expOk);
    logic seen;
    seen = 1'b0;
    hsyncIn <= 1'b1;
    repeat (200) begin
      @(posedge sys_clk);
      seen |= (syncOk === 1'b1);
    end
    hsyncIn <= 1'b0;
    repeat (20) begin
      @(posedge sys_clk);
      seen |= (syncOk === 1'b1);
    end
    check(seen, expOk);
  endtask
  task automatic testDefaults();
    check({ctl.lineDriveRunning,
      ctl.pllFreqIncrement}, 6'h34);
    regWrite(SUB_PLL0, 8'h00, 1'b0);
    readPair();
    check({rdA, rdB}, 16'h0000);
    $display("defaults done");
  endtask
  task automatic testControl();
    logic [8:0] r;
    hm.busStart();
    hm.xfer({DEV_ADDR, 2'b01}, r);
    hm.xfer({SUB_MAIN, 1'b1}, r);
    hm.xfer(9'h12d, r);
    hm.xfer(9'h04b, r);
    hm.busStop();
    repeat (10) @(posedge sys_clk);
    check({ctl.vertOutputKill, ctl.vertProtectEnable, ctl.externalClockChosen,
      ctl.lineDriveDutySelect, ctl.lineDriveRunning,
      lineDrv}, 6'h2d);
    check({ctl.selfAdaptOn, ctl.driveClipOn, ctl.guardBandItemsOn,
      ctl.vertDynamicComp,
      ctl.blankingItemsOn}, 5'h0b);
    readPair();
    check({rdA, rdB}, 16'h9625);
    for (int m = 0; m < 4; m++) begin
      regWrite(SUB_AUX, {m[1:0], 6'h02}, 1'b1);
      check({ctl.blackSwitchoffMode, ctl.lineDriveRunning,
        ctl.shrinkOverscanJump}, {m[1:0], m != 0, 1'b1});
    end
    $display("control done");
  endtask
  task automatic testLine();
    int lows;
    regWrite(SUB_MAIN, 8'h01, 1'b1);
    lowCount(lows);
    check(lows, LP * 45 / 100);
    regWrite(SUB_MAIN, 8'h03, 1'b1);
    lowCount(lows);
    check(lows, LP * 40 / 100);
    regWrite(SUB_MAIN, 8'h61, 1'b1);
    lowCount(lows);
    check({ctl.standbyRequest, ctl.autoLineRateDetect,
      lows == 0 || lows == LP}, 3'h7);
    regWrite(SUB_MAIN, 8'h01, 1'b1);
    $display("line done");
  endtask
  task automatic testPwm();
    logic [7:0] codes [8];
    logic [6:0] lvl;
    int highs;
    codes = '{8'h80, 8'hc0, 8'h00, 8'h40, 8'h7c, 8'h82, 8'h01, 8'h03};
    foreach (codes[i]) begin
      regWrite(SUB_PWM, codes[i], 1'b1);
      lvl = {~codes[i][7], codes[i][6:2], codes[i][1]};
      highs = 0;
      repeat (108) begin
        @(posedge sys_clk);
        highs += int'(pwmOut === 1'b1);
      end
      check(highs,
        codes[i][0] ? 0 : (lvl > 108 ? 108 : lvl));
      check({ctl.pwmModeSelect, ctl.pwmLevelCode},
        {codes[i][1:0], codes[i][7:2]});
    end
    $display("pwm done");
  endtask
  task automatic testVsync();
    regWrite(SUB_VSYNC, 8'hff, 1'b1);
    readPair();
    check({rdA, rdB, ctl.forceProgressive}, 17'h05001);
    verticalBlankIn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check(sandOut, 1'b0);
    regWrite(SUB_VSYNC, 8'h08, 1'b1);
    check({sandOut, ctl.forceProgressive}, 2'h3);
    verticalBlankIn <= 1'b0;
    lineBlankIn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check(sandOut, 1'b1);
    lineBlankIn <= 1'b0;
    $display("vsync done");
  endtask
  task automatic testPll();
    regWrite(SUB_PLL1, 8'h05, 1'b1);
    check({ctl.freeRunGenerator, ctl.tapeFilterMode, ctl.noisyTapeHandling,
      ctl.minSyncWidthSelect, ctl.thirdLoopTimeConstant}, 5'h00);
    syncTry(1'b0);
    regWrite(SUB_PLL1, 8'h02, 1'b1);
    syncTry(1'b1);
    regWrite(SUB_PLL1, 8'h1f, 1'b1);
    check({ctl.freeRunGenerator, ctl.tapeFilterMode, ctl.noisyTapeHandling,
      ctl.minSyncWidthSelect,
      ctl.thirdLoopTimeConstant}, 5'h1f);
    regWrite(SUB_PLL0, 8'h0a, 1'b1);
    readPair();
    check({rdA, rdB, ctl.pllFreqIncrement}, 21'h143f4);
    regWrite(8'h05, 8'h5a, 1'b1);
    readPair();
    check(rdA, 8'h00);
    $display("pll done");
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge sys_clk);
    testDefaults();
    testControl();
    testLine();
    testPwm();
    testVsync();
    testPll();
    end_sim();
  end
  // Watchdog: bus traffic needs about 340 us; stay under 100k cycles
  initial begin
    #450_000;
    miscompares++;
    end_sim();
  end
endmodule
bind dcr_regs dcr_regs_assertions chk_u (.sys_clk, .rst_n, .sdaOe,
  .lineBlankIn, .verticalBlankIn, .ctl, .lineDriveOutput, .pwmOutput,
  .sandcastleOutput);
`default_nettype wire
